// File: design/acc_pkg.sv
// package of constants and carrier types for the converter back end
//--------------------------------------------------------------------
//--------------------------------------------------------------------
package acc_pkg;
    localparam int          ACC_RES        = 20;           // resolution variant built
    localparam int          ACC_ACC_W      = 24;           // density accumulator width
    localparam int          ACC_GAIN_FRAC  = 16;           // gain factor fraction bits
    localparam int          ACC_GAIN_W     = 24;           // gain factor width
    localparam int          ACC_CAL_CYC    = 3246;         // master cycles, full calibration
    localparam int          ACC_STEP_TICKS = ACC_CAL_CYC / 4; // internal ticks per step
    localparam int          ACC_CONV_TICKS = 811;          // internal ticks per conversion
    localparam int          ACC_COMB_LEN   = 64;           // comb section length
    localparam logic [11:0] ACC_CNT_ZERO   = 12'h000;
    localparam logic [ACC_RES-1:0] ACC_ALL_ONES = {ACC_RES{1'b1}};
    localparam logic [ACC_RES-1:0] ACC_ALL_ZERO = {ACC_RES{1'b0}};
    localparam logic [ACC_RES-1:0] ACC_HALF     = {1'b1, {(ACC_RES-1){1'b0}}};
    localparam logic [ACC_GAIN_W-1:0] ACC_GAIN_ONE = 24'h010000;

    // modulator source selection
    typedef enum logic [1:0] {
        ACC_MUX_CHAN = 2'h0,  // selected channel
        ACC_MUX_ZERO = 2'h1,  // both inputs on negative reference
        ACC_MUX_FULL = 2'h2   // positive and negative reference
    } acc_mux_type;

    // control pins from the controller
    typedef struct packed {
        logic cal_req;              // calibration request, level
        logic conv_req;             // conversion request, level
        logic polarity_select;      // 1 bipolar, 0 unipolar
        logic channel_select_high;
        logic channel_select_low;
    } acc_ctrl_type;

    // result word with its strobe
    typedef struct packed {
        logic               valid;
        logic [ACC_RES-1:0] word;
    } acc_result_type;
endpackage

// File: design/acc_filter.sv
// comb plus low-pass decimation filter of the modulator bit stream
`timescale 1ns/1ps
module acc_filter (
    // clock and reset
    input  wire logic                          i_core_clk,
    input  wire logic                          i_resetn,
    // control
    input  wire logic                          i_tick,
    input  wire logic                          i_clear,
    input  wire logic                          i_mod_bit,
    // result
    output logic [acc_pkg::ACC_ACC_W-1:0]      o_density
);
    import acc_pkg::*;

    logic [ACC_COMB_LEN-1:0]  hist_r;   // comb delay line
    logic [ACC_ACC_W-1:0]     comb_r;   // running comb sum
    logic [ACC_ACC_W-1:0]     lp_r;     // low-pass integrator

    //------------------------------------------------
    // comb then low-pass, both stepped by the tick
    //------------------------------------------------
    // response scales with the tick rate, so with the master clock
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn || i_clear) begin
            hist_r <= '0;
            comb_r <= '0;
            lp_r   <= '0;
        end else if (i_tick) begin
            hist_r <= {hist_r[ACC_COMB_LEN-2:0], i_mod_bit};
            comb_r <= comb_r + ACC_ACC_W'(i_mod_bit)
                      - ACC_ACC_W'(hist_r[ACC_COMB_LEN-1]);
            lp_r   <= lp_r + comb_r;
        end
    end

    assign o_density = lp_r;
endmodule

// File: design/acc_core.sv
// calibration sequencer and output coding of the converter back end
`timescale 1ns/1ps
module acc_core (
    // clock and reset
    input  wire logic                           i_core_clk,
    input  wire logic                           i_resetn,
    // controller pins
    input  wire acc_pkg::acc_ctrl_type          i_ctrl,
    // modulator
    input  wire logic                           i_mod_bit,
    output acc_pkg::acc_mux_type                o_mux_sel,
    // status and result
    output logic                                o_calibrating,
    output logic                                o_cal_done,
    output acc_pkg::acc_result_type             o_result
);
    import acc_pkg::*;

    //------------------------------------------------
    // state
    //------------------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,   // standby
        ST_OFS  = 5'h02,   // offset step
        ST_GAIN = 5'h04,   // gain step
        ST_CONV = 5'h08,   // conversion
        ST_CALC = 5'h10    // gain factor division
    } acc_state_type;

    acc_state_type            state_r;
    logic                     half_r;       // internal divide by two
    logic                     tick;         // one-cycle enable, half rate
    logic [11:0]              cnt_r;        // ticks left in step
    logic                     cal_q_r;      // previous cal command, cal and conv requests both high
    logic                     conv_q_r;     // previous conv request
    logic                     cal_start;    // new calibration request
    logic                     conv_start;   // new conversion request
    logic [ACC_ACC_W-1:0]     density;      // filter output
    logic                     f_clear;      // filter restart
    logic [ACC_ACC_W-1:0]     zero_r;       // stored zero scale code
    logic [ACC_ACC_W-1:0]     span_r;       // full minus zero
    logic [ACC_GAIN_W-1:0]    gain_r;       // stored gain factor
    logic [ACC_GAIN_W-1:0]    quo_r;        // divider quotient
    logic [ACC_ACC_W+ACC_GAIN_FRAC:0] rem_r; // divider remainder
    logic [4:0]               div_cnt_r;    // divider bits left
    logic                     pol_bip;      // polarity sampled at word end

    //------------------------------------------------
    // clamp a signed scaled value into the word range
    //------------------------------------------------
    function automatic logic [ACC_RES-1:0] clamp(input logic signed [47:0] v);
        if (v < 0)
            clamp = ACC_ALL_ZERO;
        else if (v > 48'(ACC_ALL_ONES))
            clamp = ACC_ALL_ONES;
        else
            clamp = v[ACC_RES-1:0];
    endfunction

    acc_filter u_filter (
        .i_core_clk (i_core_clk),
        .i_resetn   (i_resetn),
        .i_tick     (tick),
        .i_clear    (f_clear),
        .i_mod_bit  (i_mod_bit),
        .o_density  (density)
    );

    //------------------------------------------------
    // divide master clock by two
    //------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn)
            half_r <= 1'b0;
        else
            half_r <= ~half_r;
    end
    assign tick = half_r;

    //------------------------------------------------
    // request edges
    //------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            cal_q_r  <= 1'b0;
            conv_q_r <= 1'b0;
        end else begin
            cal_q_r  <= i_ctrl.cal_req && i_ctrl.conv_req;
            conv_q_r <= i_ctrl.conv_req;
        end
    end
    // a cal command restarts even a running calibration
    assign cal_start  = i_ctrl.cal_req && i_ctrl.conv_req && !(cal_q_r && conv_q_r);
    assign conv_start = i_ctrl.conv_req && !conv_q_r;
    // a restart in conversion and the step out of the divide both begin a fresh word,
    // otherwise stale ticks leak into the first result
    assign f_clear    = cal_start
                        || (conv_start && (state_r == ST_IDLE || state_r == ST_CONV))
                        || (state_r == ST_CALC && div_cnt_r == 5'h00)
                        || (tick && cnt_r == ACC_CNT_ZERO && state_r != ST_CALC
                            && state_r != ST_IDLE);

    //------------------------------------------------
    // sequencer
    //------------------------------------------------
    // two steps of equal length, then the gain division, make the whole calibration
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            state_r <= ST_IDLE;
            cnt_r   <= ACC_CNT_ZERO;
        end else if (cal_start) begin
            state_r <= ST_OFS;
            cnt_r   <= 12'(ACC_STEP_TICKS - 1);
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (conv_start) begin
                        state_r <= ST_CONV;
                        cnt_r   <= 12'(ACC_CONV_TICKS - 1);
                    end
                end
                ST_OFS: begin
                    if (tick) begin
                        if (cnt_r == ACC_CNT_ZERO) begin
                            state_r <= ST_GAIN;
                            cnt_r   <= 12'(ACC_STEP_TICKS - 1);
                        end else
                            cnt_r <= cnt_r - 12'h001;
                    end
                end
                ST_GAIN: begin
                    if (tick) begin
                        if (cnt_r == ACC_CNT_ZERO)
                            state_r <= ST_CALC;
                        else
                            cnt_r <= cnt_r - 12'h001;
                    end
                end
                ST_CALC: begin
                    if (div_cnt_r == 5'h00)
                        state_r <= i_ctrl.conv_req ? ST_CONV : ST_IDLE;
                    if (div_cnt_r == 5'h00)
                        cnt_r <= 12'(ACC_CONV_TICKS - 1);
                end
                ST_CONV: begin
                    if (conv_start)
                        cnt_r <= 12'(ACC_CONV_TICKS - 1);
                    else if (tick) begin
                        if (cnt_r == ACC_CNT_ZERO) begin
                            state_r <= i_ctrl.conv_req ? ST_CONV : ST_IDLE;
                            cnt_r   <= 12'(ACC_CONV_TICKS - 1);
                        end else
                            cnt_r <= cnt_r - 12'h001;
                    end
                end
            endcase
        end
    end

    //------------------------------------------------
    // modulator input routing
    //------------------------------------------------
    always_comb begin
        unique case (state_r)
            ST_OFS:  o_mux_sel = ACC_MUX_ZERO;
            ST_GAIN: o_mux_sel = ACC_MUX_FULL;
            default: o_mux_sel = ACC_MUX_CHAN;
        endcase
    end

    //------------------------------------------------
    // coefficient capture and gain division
    //------------------------------------------------
    // restoring divide: gain = 2^frac * fullscale_code / span
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            zero_r    <= '0;
            span_r    <= '0;
            gain_r    <= ACC_GAIN_ONE;
            quo_r     <= '0;
            rem_r     <= '0;
            div_cnt_r <= 5'h00;
        end else if (tick && cnt_r == ACC_CNT_ZERO && state_r == ST_OFS) begin
            zero_r <= density;
        end else if (tick && cnt_r == ACC_CNT_ZERO && state_r == ST_GAIN) begin
            span_r    <= (density > zero_r) ? density - zero_r : ACC_ACC_W'(1);
            quo_r     <= '0;
            // top dividend bits preloaded, so the steps yield only the low quotient bits;
            // limitation: the reference span must exceed this preload
            rem_r     <= (ACC_ACC_W+ACC_GAIN_FRAC+1)'(
                             ACC_ALL_ONES[ACC_RES-1:ACC_GAIN_W-ACC_GAIN_FRAC]);
            div_cnt_r <= 5'(ACC_GAIN_W);
        end else if (state_r == ST_CALC && div_cnt_r != 5'h00) begin
            // dividend bit stream is ALL_ONES shifted up by frac bits
            if ({rem_r[ACC_ACC_W+ACC_GAIN_FRAC-1:0],
                 (div_cnt_r > 5'(ACC_GAIN_FRAC))} >= {17'h00000, span_r}) begin
                rem_r <= {rem_r[ACC_ACC_W+ACC_GAIN_FRAC-1:0],
                          (div_cnt_r > 5'(ACC_GAIN_FRAC))} - {17'h00000, span_r};
                quo_r <= {quo_r[ACC_GAIN_W-2:0], 1'b1};
            end else begin
                rem_r <= {rem_r[ACC_ACC_W+ACC_GAIN_FRAC-1:0],
                          (div_cnt_r > 5'(ACC_GAIN_FRAC))};
                quo_r <= {quo_r[ACC_GAIN_W-2:0], 1'b0};
            end
            div_cnt_r <= div_cnt_r - 5'h01;
        end else if (state_r == ST_CALC) begin
            gain_r <= quo_r;
        end
    end

    //------------------------------------------------
    // output coding at end of each conversion
    //------------------------------------------------
    // polarity is read only here, never during calibration
    assign pol_bip = i_ctrl.polarity_select;
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            o_result <= '0;
        end else if (state_r == ST_CONV && tick && cnt_r == ACC_CNT_ZERO
                     && !conv_start && !cal_start) begin    // calibration drops the word
            o_result.valid <= 1'b1;
            if (pol_bip)
                // same factors, half the slope, mid code at zero
                o_result.word <= clamp(48'(signed'({1'b0, ACC_HALF}))
                    + ((48'(signed'({1'b0, density})) - 48'(signed'({1'b0, zero_r})))
                       * 48'(signed'({1'b0, gain_r})) >>> (ACC_GAIN_FRAC + 1)));
            else
                // subtract zero, scale, clamp
                o_result.word <= clamp((48'(signed'({1'b0, density}))
                    - 48'(signed'({1'b0, zero_r})))
                    * 48'(signed'({1'b0, gain_r})) >>> ACC_GAIN_FRAC);
        end else begin
            o_result.valid <= 1'b0;
        end
    end

    assign o_calibrating = (state_r == ST_OFS) || (state_r == ST_GAIN) || (state_r == ST_CALC);

    //------------------------------------------------
    // end-of-calibration pulse
    //------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn)
            o_cal_done <= 1'b0;
        else
            o_cal_done <= (state_r == ST_CALC) && (div_cnt_r == 5'h00) && !cal_start;
    end
endmodule

// File: tb/acc_core_monitor.sv
// port-level assertion checker for the converter back end
`timescale 1ns/1ps
module acc_core_monitor
    import acc_pkg::*;
(
    // clock and reset
    input wire logic                    i_core_clk,
    input wire logic                    i_resetn,
    // watched ports
    input wire acc_pkg::acc_ctrl_type   i_ctrl,
    input wire acc_pkg::acc_mux_type    o_mux_sel,
    input wire logic                    o_calibrating,
    input wire logic                    o_cal_done,
    input wire acc_pkg::acc_result_type o_result
);
    // ----------------------------------------
    // helper counters
    // ----------------------------------------
    localparam int CAL_MIN = 3244;   // tick-aligned lower bound
    localparam int CAL_MAX = 3300;   // allows for the divide tail
    logic        both_r;             // both requests high last cycle
    logic        start;              // calibration request edge
    logic [12:0] cal_cnt_r;          // cycles since the request edge
    logic [12:0] zero_cnt_r;         // cycles in the offset step
    assign start = i_ctrl.cal_req && i_ctrl.conv_req && !both_r;
    // the calibration counter saturates so a long idle spell never wraps
    always_ff @(posedge i_core_clk) begin
        both_r     <= i_resetn && i_ctrl.cal_req && i_ctrl.conv_req;
        cal_cnt_r  <= (start || !i_resetn) ? 13'h0000 : cal_cnt_r + {12'h000, ~&cal_cnt_r};
        zero_cnt_r <= (o_mux_sel == ACC_MUX_ZERO && !start) ? zero_cnt_r + 13'h0001 : 13'h0000;
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);
    // ----------------------------------------
    // sequences and assertions
    // ----------------------------------------
    sequence seq_zero_exit;
        (o_mux_sel == ACC_MUX_ZERO) ##1 (o_mux_sel != ACC_MUX_ZERO);
    endsequence
    sequence seq_zero_to_full;
        (o_mux_sel == ACC_MUX_ZERO) ##1 (o_mux_sel == ACC_MUX_FULL);
    endsequence
    AST_CAL_START: assert property (start |=> o_calibrating && o_mux_sel == ACC_MUX_ZERO)
        else $error("calibration did not start on the request edge");
    AST_OFFSET_THEN_GAIN: assert property (seq_zero_exit |-> o_mux_sel == ACC_MUX_FULL)
        else $error("offset step not followed by gain step");
    AST_OFFSET_LEN: assert property (seq_zero_to_full |-> $past(zero_cnt_r) inside {[1618:1626]})
        else $error("offset step length wrong");
    AST_CAL_LEN: assert property (o_cal_done |-> cal_cnt_r inside {[CAL_MIN:CAL_MAX]})
        else $error("calibration length wrong");
    AST_DONE_PULSE: assert property (o_cal_done |-> !o_calibrating ##1 !o_cal_done)
        else $error("calibration done not a single pulse");
    AST_IDLE_MUX: assert property (!o_calibrating |-> o_mux_sel == ACC_MUX_CHAN)
        else $error("reference routed outside calibration");
    AST_VALID_PULSE: assert property (o_result.valid |=> !o_result.valid)
        else $error("result strobe longer than one cycle");
    AST_WORD_HOLDS: assert property (!o_result.valid |-> $stable(o_result.word))
        else $error("result word moved without strobe");
    AST_NO_RESULT_IN_CAL: assert property (o_calibrating |-> !o_result.valid)
        else $error("result produced during calibration");
endmodule

bind acc_core acc_core_monitor u_mon (
    .i_core_clk    (i_core_clk),
    .i_resetn      (i_resetn),
    .i_ctrl        (i_ctrl),
    .o_mux_sel     (o_mux_sel),
    .o_calibrating (o_calibrating),
    .o_cal_done    (o_cal_done),
    .o_result      (o_result)
);

// File: tb/acc_mod_src.sv
// modulator stand-in: ones-density stream for channel or reference
`timescale 1ns/1ps
module acc_mod_src
    import acc_pkg::*;
(
    // clock and reset
    input  wire logic                 i_core_clk,
    input  wire logic                 i_resetn,
    // source selection and levels out of 256
    input  wire acc_pkg::acc_mux_type i_mux_sel,
    input  wire logic [7:0]           i_chan_lvl,
    input  wire logic [7:0]           i_zero_lvl,
    input  wire logic [7:0]           i_full_lvl,
    // bit stream
    output logic                      o_mod_bit
);
    logic       phase_r;  // steps at half rate so tick phase never matters
    logic [7:0] acc_r;    // first-order density accumulator
    logic [7:0] lvl;      // level of the routed source
    // routing follows the block's source selection
    always_comb begin
        case (i_mux_sel)
            ACC_MUX_ZERO: lvl = i_zero_lvl;
            ACC_MUX_FULL: lvl = i_full_lvl;
            default:      lvl = i_chan_lvl;
        endcase
    end
    // carry of the accumulator is the output bit
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            phase_r   <= 1'b0;
            acc_r     <= 8'h00;
            o_mod_bit <= 1'b0;
        end else begin
            phase_r <= ~phase_r;
            if (phase_r) begin
                {o_mod_bit, acc_r} <= {1'b0, acc_r} + {1'b0, lvl};
            end
        end
    end
endmodule

// File: tb/testbench.sv
// self-checking bench for the converter back end
`timescale 1ns/1ps
module testbench;
    import acc_pkg::*;
    // ----------------------------------------
    // stimulus and observation
    // ----------------------------------------
    logic           i_core_clk = 1'b0;  // 100 MHz
    logic           i_resetn   = 1'b0;
    acc_ctrl_type   i_ctrl     = '0;
    logic           mod_bit;
    acc_mux_type    mux_sel;
    logic           calibrating;
    logic           cal_done;
    acc_result_type result;
    logic [7:0]     chan_lvl   = 8'h40;  // input density
    logic [7:0]     zero_lvl   = 8'h40;  // negative reference density
    logic [7:0]     full_lvl   = 8'hC0;  // positive reference density
    int             failures   = 0;
    int             n_checks   = 0;
    int             cycles     = 0;
    always #5 i_core_clk = ~i_core_clk;
    acc_core u_dut (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_ctrl(i_ctrl),
        .i_mod_bit(mod_bit), .o_mux_sel(mux_sel), .o_calibrating(calibrating),
        .o_cal_done(cal_done), .o_result(result));
    acc_mod_src u_src (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_mux_sel(mux_sel),
        .i_chan_lvl(chan_lvl), .i_zero_lvl(zero_lvl), .i_full_lvl(full_lvl),
        .o_mod_bit(mod_bit));
    // ----------------------------------------
    // compare and helper tasks
    // ----------------------------------------
    task automatic check_bit(string what, logic exp, logic seen);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %b seen %b", what, exp, seen);
        end
    endtask
    task automatic check_word(string what, logic [19:0] exp, int tol, logic [19:0] seen);
        int d;
        n_checks++;
        d = int'(seen) - int'(exp);
        if ((^seen === 1'bx) || d > tol || d < -tol) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // ideal word from densities; gain maps the reference span to full scale
    function automatic logic [19:0] exp_word(int lvl, logic bip);
        int v;
        v = (lvl - int'(zero_lvl)) * (bip ? 32'sh80000 : 32'sh100000)
            / (int'(full_lvl) - int'(zero_lvl));
        v = bip ? v + 32'sh80000 : v;
        v = (v > 32'shFFFFF) ? 32'shFFFFF : ((v < 0) ? 0 : v);
        return v[19:0];
    endfunction
    // bounded wait on the strobe or the calibration pulse
    task automatic wait_for(input bit want_valid, input int lim, output int n);
        n = 0;
        do begin
            @(negedge i_core_clk);
            n++;
        end while (((want_valid ? result.valid : cal_done) !== 1'b1) && n < lim);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic test_reset();
        check_bit("calibrating", 1'b0, calibrating);
        check_bit("mux idle", 1'b1, mux_sel === ACC_MUX_CHAN);
        check_word("word", ACC_ALL_ZERO, 0, result.word);
        $display("test reset done");
    endtask
    // second request mid-way either restarts or is ignored
    task automatic run_cal(input int mid, input logic restart);
        int m;
        int d;
        // channel and polarity settle with the request and stay put
        i_ctrl = '{cal_req: 1'b1, conv_req: 1'b1, polarity_select: 1'b1,
                   channel_select_high: 1'b1, channel_select_low: 1'b0};
        repeat (2) @(negedge i_core_clk);
        i_ctrl.cal_req  = 1'b0;
        i_ctrl.conv_req = 1'b0;
        repeat (mid) @(negedge i_core_clk);
        i_ctrl.cal_req  = restart;
        i_ctrl.conv_req = 1'b1;
        @(negedge i_core_clk);
        i_ctrl.cal_req  = 1'b0;
        i_ctrl.conv_req = 1'b0;
        wait_for(1'b0, 5000, m);
        d = restart ? m + 1 : m + mid + 3;
        check_bit("cal done", 1'b1, cal_done);
        check_bit("cal length", 1'b1, d >= 3244 && d <= 3300);
        $display("test calibration restart %0d done", restart);
    endtask
    task automatic run_conv(input logic [7:0] lvl, input logic bip, input logic [1:0] ch);
        int m;
        logic [19:0] e;
        chan_lvl = lvl;
        i_ctrl.polarity_select = bip;
        {i_ctrl.channel_select_high, i_ctrl.channel_select_low} = ch;
        i_ctrl.conv_req = 1'b1;
        wait_for(1'b1, 2000, m);
        i_ctrl.conv_req = 1'b0;
        e = exp_word(lvl, bip);
        check_bit("result valid", 1'b1, result.valid);
        check_word("result word", e, (e == ACC_ALL_ONES || e == ACC_ALL_ZERO) ? 0 : 'h2000,
            result.word);
        // let the dropped request be seen so the next one is a fresh edge
        @(negedge i_core_clk);
        $display("test conversion level %h polarity %0d done", lvl, bip);
    endtask
    // ----------------------------------------
    // main sequence and hang guard
    // ----------------------------------------
    initial begin
        logic [7:0] lvls [4];
        lvls = '{8'h60, 8'h80, 8'hFF, 8'h00};
        repeat (16) @(negedge i_core_clk);
        i_resetn = 1'b1;
        @(negedge i_core_clk);
        test_reset();
        run_cal(1000, 1'b0);
        for (int i = 0; i < 8; i++) begin
            run_conv(lvls[i % 4], i[2], i[1:0]);
        end
        zero_lvl = 8'h00;
        run_cal(1000, 1'b1);
        run_conv(8'h40, 1'b0, 2'h0);
        tally_and_finish();
    end
    // long enough for two calibrations and nine conversions
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            tally_and_finish();
        end
    end
endmodule
